// *** hdl/peripheral_irq_group2.v ***
// Group-2 peripheral interrupt enables, flags and request gating behind an APB slave.
//
// Behaviour
// R1: One enable register holds an enable bit for comparator, write, collision and capcmp2.
// R2: No group-2 request reaches the processor unless the peripheral enable is set.
// R3: Enable bit 6 allows the comparator interrupt when 1 and blocks it when 0.
// R4: Enable bit 4 allows the nonvolatile write interrupt when 1 and blocks it when 0.
// R5: Enable bit 3 allows the bus collision interrupt when 1 and blocks it when 0.
// R6: Enable bit 0 allows the capture/compare 2 interrupt when 1 and blocks it when 0.
// R7: Enable bits 7, 5, 2 and 1 read zero and ignore writes.
// R8: One flag register holds a latched flag for each of the same four sources.
// R9: A flag sets on its event whatever its enable and the global enable are.
// R10: Software should clear stale flags before enabling an interrupt.
// R11: The flag register sits at index 0Dh with flags at bits 6, 4, 3 and 0, others zero.
// R12: A set flag stays set until software writes it to zero; hardware never clears it.
// R13: The capcmp2 flag sets on capture or compare match by mode and is unused in PWM mode.
// R14: The collision flag sets only as I2C master; the write flag sets on write completion.
// R15: Implemented enable bits reset to zero.
// R16: The request rises when a flag and its enable are set with peripheral and global enable.
`timescale 1ns/1ps
`include "peripheral_irq_group2_regs.vh"
module peripheral_irq_group2
(
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // APB slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   // Event levels from peripherals, asynchronous to this block
   input wire comparator_change_i,
   input wire nv_write_done_i,
   input wire collision_i,
   input wire capture_i,
   input wire compare_match_i,
   // Peripheral modes
   input wire i2c_master_mode_i,
   input wire [1:0] capcmp2_mode_i,
   // Request to the processor
   output wire irq_o
);

   // --------------------------------------------------------------
   // Register decode
   // --------------------------------------------------------------
   reg [7:0] peripheral_irq_enable_2;
   reg [7:0] peripheral_irq_flags_2;
   reg [7:0] main_irq_control;
   reg [31:0] rdata;

   function [11:0] byte_addr;
      input [7:0] index;
      begin
         byte_addr = {2'b00, index, 2'b00};
      end
   endfunction

   wire access = psel_i & penable_i;
   wire wr = access & pwrite_i;
   wire hit_en = (paddr_i == byte_addr(`ENABLE_2_INDEX));
   wire hit_fl = (paddr_i == byte_addr(`FLAGS_2_INDEX));
   wire hit_main = (paddr_i == byte_addr(`MAIN_CTRL_INDEX));
   wire mapped = hit_en | hit_fl | hit_main;

   // Zero-wait slave; unmapped addresses answer with an error.
   assign pready_o = 1'b1;
   assign pslverr_o = access & ~mapped;
   assign prdata_o = rdata;

   // --------------------------------------------------------------
   // Event capture
   // --------------------------------------------------------------
   wire [4:0] raw_levels = {comparator_change_i, nv_write_done_i, collision_i,
                            capture_i, compare_match_i};
   wire [4:0] pulses;

   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1)
      begin : g_edge
         event_edge u_edge
         (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .level_i(raw_levels[g]),
            .pulse_o(pulses[g])
         );
      end
   endgenerate

   // Mode straps are slow but come from another block's domain, so sync them too.
   reg [2:0] mode_meta;
   reg [2:0] mode_sync;
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mode_meta <= 3'h0;
         mode_sync <= 3'h0;
      end
      else
      begin
         mode_meta <= {i2c_master_mode_i, capcmp2_mode_i};
         mode_sync <= mode_meta;
      end
   end

   wire i2c_master = mode_sync[2];
   wire [1:0] ccp_mode = mode_sync[1:0];

   reg [7:0] set_vec;
   always @*
   begin
      set_vec = 8'h00;
      set_vec[`BIT_COMPARATOR] = pulses[4]; // [R9]
      set_vec[`BIT_NV_WRITE] = pulses[3]; // [R14]
      set_vec[`BIT_COLLISION] = pulses[2] & i2c_master; // [R14]
      case (ccp_mode) // [R13]
         `CCP_MODE_CAPTURE: set_vec[`BIT_CAPCMP2] = pulses[1];
         `CCP_MODE_COMPARE: set_vec[`BIT_CAPCMP2] = pulses[0];
         default: set_vec[`BIT_CAPCMP2] = 1'b0;
      endcase
   end

   // --------------------------------------------------------------
   // Registers
   // --------------------------------------------------------------
   wire [7:0] wbyte = pwdata_i[7:0];
   wire [7:0] next_flags = wr & hit_fl ? (wbyte & `IMPL_MASK) : peripheral_irq_flags_2;

   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         peripheral_irq_enable_2 <= `ENABLE_2_RESET; // [R15]
         peripheral_irq_flags_2 <= `FLAGS_2_RESET;
         main_irq_control <= `MAIN_CTRL_RESET;
      end
      else
      begin
         if (wr & hit_en)
            peripheral_irq_enable_2 <= wbyte & `IMPL_MASK; // [R1] [R7]
         if (wr & hit_main)
            main_irq_control <= wbyte & 8'hc0;
         // A set arriving with a clearing write wins; only software clears. [R8] [R12]
         peripheral_irq_flags_2 <= next_flags | set_vec; // [R11]
      end
   end

   always @*
   begin
      rdata = 32'h00000000;
      if (hit_en)
         rdata[7:0] = peripheral_irq_enable_2 & `IMPL_MASK; // [R7]
      else if (hit_fl)
         rdata[7:0] = peripheral_irq_flags_2 & `IMPL_MASK; // [R11]
      else if (hit_main)
         rdata[7:0] = main_irq_control;
   end

   // --------------------------------------------------------------
   // Request gating
   // --------------------------------------------------------------
   // Each enable bit gates its own flag. [R3] [R4] [R5] [R6]
   wire [7:0] pending = peripheral_irq_flags_2 & peripheral_irq_enable_2 & `IMPL_MASK;
   wire peripheral_group_enable = main_irq_control[`BIT_PERIPH_EN];
   wire global_irq_enable = main_irq_control[`BIT_GLOBAL_EN];

   // Flags latch regardless of enables, so stale flags fire on enabling. [R10]
   assign irq_o = (|pending) & peripheral_group_enable & global_irq_enable; // [R2] [R16]

endmodule // peripheral_irq_group2

// *** hdl/peripheral_irq_group2_regs.vh ***
// Register offsets, field positions and reset values of the group-2 interrupt block.
`ifndef PERIPHERAL_IRQ_GROUP2_REGS_VH
`define PERIPHERAL_IRQ_GROUP2_REGS_VH

// Register indices as printed; byte address is four times the index.
`define ENABLE_2_INDEX 8'h8d
`define FLAGS_2_INDEX 8'h0d
`define MAIN_CTRL_INDEX 8'h0b

// Field positions shared by enable and flag registers.
`define BIT_CAPCMP2 0
`define BIT_COLLISION 3
`define BIT_NV_WRITE 4
`define BIT_COMPARATOR 6

// Main control fields.
`define BIT_PERIPH_EN 6
`define BIT_GLOBAL_EN 7

// Implemented bits of the enable and flag registers.
`define IMPL_MASK 8'h59
`define ENABLE_2_RESET 8'h00
`define FLAGS_2_RESET 8'h00
`define MAIN_CTRL_RESET 8'h00

// Capture/compare mode encodings.
`define CCP_MODE_CAPTURE 2'h0
`define CCP_MODE_COMPARE 2'h1
`define CCP_MODE_PWM 2'h2

`endif

// *** hdl/event_edge.v ***
// Synchroniser and rising-edge pulse generator for one event line.
`timescale 1ns/1ps
module event_edge
(
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Event line
   input wire level_i,
   output wire pulse_o
);

   reg meta;
   reg sync;
   reg last;

   // The edge detector looks only at the second and third stages, never the first.
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta <= 1'b0;
         sync <= 1'b0;
         last <= 1'b0;
      end
      else
      begin
         meta <= level_i;
         sync <= meta;
         last <= sync;
      end
   end

   assign pulse_o = sync & ~last;

endmodule // event_edge

// *** verif/peripheral_irq_group2_monitor.sv ***
// Port checker of the group-2 interrupt block.
`timescale 1ns/1ps
module peripheral_irq_group2_monitor
(
   input wire clk_i, rst_i, psel_i, penable_i, pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] prdata_o,
   input wire pslverr_o, irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire ctl = psel_i && paddr_i == 12'h02c;
   wire hit = paddr_i == 12'h02c || paddr_i == 12'h034 || paddr_i == 12'h234;
   a_upper_zero: assert property (prdata_o[31:8] == 24'h0)
      else $error("upper bits");
   a_enable_mask: assert property (psel_i && paddr_i == 12'h234 |-> !(|(prdata_o[7:0] & 8'ha6)))
      else $error("enable spare");
   a_flag_mask: assert property (psel_i && paddr_i == 12'h034 |-> !(|(prdata_o[7:0] & 8'ha6)))
      else $error("flag spare");
   a_periph_gate: assert property (ctl && !prdata_o[6] |-> !irq_o)
      else $error("periph gate");
   a_global_gate: assert property (ctl && !prdata_o[7] |-> !irq_o)
      else $error("global gate");
   a_irq_fall_cause: assert property ($fell(irq_o) |-> $past(psel_i && penable_i && pwrite_i))
      else $error("irq fell");
   a_bad_addr: assert property (psel_i && penable_i && !hit |-> pslverr_o)
      else $error("no error");
   a_reset_idle: assert property ($fell(rst_i) |-> !irq_o)
      else $error("irq at reset");
endmodule // peripheral_irq_group2_monitor

// *** verif/periph_event_model.sv ***
// Peripheral event sources feeding the block.
`timescale 1ns/1ps
module periph_event_model
(
   input wire logic clk_i,
   output logic [4:0] lvl_o
);
   initial lvl_o = 5'h0;
   // Hold sets how slowly the source lets its level fall.
   task fire(input int i, input int hold);
      @(posedge clk_i);
      lvl_o[i] <= 1'b1;
      repeat (hold) @(posedge clk_i);
      lvl_o[i] <= 1'b0;
   endtask
endmodule // periph_event_model

// *** verif/peripheral_irq_group2_tb_top.sv ***
// Self-checking testbench of the group-2 interrupt block.
`timescale 1ns/1ps
module peripheral_irq_group2_tb_top;
   logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, i2c_m = 1;
   logic [11:0] paddr_i = 0;
   logic [31:0] pwdata_i = 0, prdata_o, r;
   logic pready_o, pslverr_o, irq_o, e;
   logic [1:0] mode = 0;
   logic [4:0] lvl;
   int num_errors = 0, n_compared = 0, cyc = 0;
   localparam logic [11:0] EN = 12'h234, FL = 12'h034, MC = 12'h02c;
   localparam logic [7:0] FB [5] = '{8'h40, 8'h10, 8'h08, 8'h01, 8'h01};
   initial forever #12.5 clk_i = ~clk_i;
   periph_event_model ev (.clk_i(clk_i), .lvl_o(lvl));
   peripheral_irq_group2 uut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .comparator_change_i(lvl[0]), .nv_write_done_i(lvl[1]), .collision_i(lvl[2]),
      .capture_i(lvl[3]), .compare_match_i(lvl[4]), .i2c_master_mode_i(i2c_m),
      .capcmp2_mode_i(mode), .irq_o(irq_o));
   task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_compared++;
      if (g !== x)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, x, g);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= {24'h0, d};
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1) @(posedge clk_i);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [7:0] x);
      apb(1'b0, a, 8'h0);
      chk("rdata", {24'h0, x}, r);
   endtask
   task irq(input logic x);
      #1 chk("irq", {31'h0, x}, {31'h0, irq_o});
   endtask
   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task t_regs;
      rd(EN, 8'h00);
      rd(FL, 8'h00);
      apb(1'b1, EN, 8'hff);
      rd(EN, 8'h59);
      apb(1'b1, 12'h100, 8'hff);
      chk("slverr", 32'h1, {31'h0, e});
      $display("t_regs done");
   endtask
   task t_flags;
      apb(1'b1, EN, 8'h00);
      for (int i = 0; i < 5; i++)
      begin
         mode <= (i == 4) ? 2'h1 : 2'h0;
         apb(1'b1, FL, 8'h00);
         ev.fire(i, i + 1);
         repeat (4) @(posedge clk_i);
         rd(FL, FB[i]);
         repeat (20) @(posedge clk_i);
         rd(FL, FB[i]);
      end
      i2c_m <= 1'b0;
      mode <= 2'h2;
      apb(1'b1, FL, 8'h00);
      for (int i = 2; i < 5; i++) ev.fire(i, 1);
      repeat (4) @(posedge clk_i);
      rd(FL, 8'h00);
      i2c_m <= 1'b1;
      mode <= 2'h0;
      $display("t_flags done");
   endtask
   task t_gate;
      for (int k = 0; k < 4; k++)
      begin
         apb(1'b1, MC, 8'hc0);
         apb(1'b1, FL, 8'h00);
         apb(1'b1, EN, FB[k]);
         ev.fire(k, 1);
         repeat (4) @(posedge clk_i);
         irq(1'b1);
         apb(1'b1, EN, 8'h59 & ~FB[k]);
         irq(1'b0);
         apb(1'b1, EN, FB[k]);
         apb(1'b1, MC, 8'h80);
         irq(1'b0);
         apb(1'b1, MC, 8'h40);
         irq(1'b0);
         apb(1'b1, MC, 8'hc0);
         apb(1'b1, FL, 8'h00);
         irq(1'b0);
      end
      $display("t_gate done");
   endtask
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_flags;
      t_gate;
      wrap_up;
   end
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         num_errors++;
         wrap_up;
      end
   end
endmodule // peripheral_irq_group2_tb_top
bind peripheral_irq_group2 peripheral_irq_group2_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .prdata_o(prdata_o), .pslverr_o(pslverr_o), .irq_o(irq_o));
